//--- logic/siw_pkg.sv
// Package: constants and types for the sleep/idle/wake controller
package siw_pkg;

  // Clock and timing
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int OST_OSC_PERIODS = 1024;
  localparam int REG_STAB_TIME_NS = 2000;
  localparam int REG_STAB_CYCLES =
    (REG_STAB_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int DLY_W = 16;

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_DOZE_IDLE = 12'h000;
  localparam logic [11:0] ADDR_VREG = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Doze/idle control field positions
  localparam int BIT_IDLE_SELECT = 7;
  localparam int BIT_DOZE_ENABLE = 6;
  localparam int BIT_ROI = 5;
  localparam int BIT_DOE = 4;
  localparam int BIT_RATIO_LO = 0;
  localparam int RATIO_W = 3;

  // Voltage regulator control field positions
  localparam int BIT_REG_LP = 1;
  localparam int BIT_VREG_FIXED_ONE = 0;

  // Status field positions
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_IN_IDLE = 1;
  localparam int BIT_IN_SLEEP = 0;

  // Reset values
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b1;

  // Doze and idle control fields
  typedef struct packed {
    logic idle_select;
    logic doze_enable_bit;
    logic recover_on_interrupt;
    logic doze_on_exit;
    logic [RATIO_W-1:0] ratio;
  } siw_doze_idle_control_t;

  // Cause of the wake-up being processed
  typedef struct packed {
    logic by_int;
    logic by_wdt;
  } siw_wake_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_IDLE,
    ST_WAKE_DLY,
    ST_RESUME
  } siw_state_t;

endpackage

//--- logic/siw_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module siw_sync
  import siw_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- logic/siw_delay_cnt.sv
// Down-counter for wake-up delays
`timescale 1ns/1ps
module siw_delay_cnt
  import siw_pkg::*;
#(
  parameter int W = DLY_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic busy
);

  logic [W-1:0] cnt;

  // Load wins over counting; a zero load never goes busy
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (load) begin
      cnt <= load_val;
      busy <= (load_val != '0);
    end else if (cnt > W'(1)) begin
      cnt <= cnt - W'(1);
    end else begin
      cnt <= '0;
      busy <= 1'b0;
    end
  end

endmodule

//--- logic/siw_top.sv
// Sleep, idle and wake-up sequencer with APB registers
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module siw_top
  import siw_pkg::*;
#(
  parameter int NUM_INT = 8,
  parameter int CSW_INT_IDX = 1,
  parameter int OST_CYCLES = OST_OSC_PERIODS,
  parameter int REG_CYCLES = REG_STAB_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU core
  input wire logic sleep_exec,
  input wire logic global_interrupt_enable,
  input wire logic handler_entry,
  input wire logic osc_is_crystal,
  input wire logic adc_on_system_clk,
  // Interrupt sources and watchdog
  input wire logic [NUM_INT-1:0] int_flags,
  input wire logic [NUM_INT-1:0] int_enables,
  input wire logic ext_int_enable,
  input wire logic wdt_timeout,
  input wire logic wdt_sleep_enable,
  // Asynchronous pins
  input wire logic ext_int_pin,
  input wire logic master_clear_input_b,
  input wire logic brownout_reset,
  input wire logic power_on_reset,
  // Clock and power controls
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic periph_fosc_clk_en,
  output logic low_freq_internal_osc_run,
  output logic high_freq_internal_osc_run,
  output logic secondary_osc_run,
  output logic clock_output_pin_en,
  output logic regulator_low_power,
  // Sequencing outputs
  output logic wdt_clear,
  output logic wdt_run_in_sleep,
  output logic adc_abort,
  output logic io_hold,
  output logic prefetch_next,
  output logic resume_next,
  output logic vector_to_isr,
  output logic device_reset_req,
  output logic doze_enable,
  output logic in_sleep,
  output logic in_idle
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  siw_state_t state;
  siw_doze_idle_control_t doze_idle_control;
  siw_wake_t wake_cause;
  logic regulator_low_power_sleep;
  logic timeout_flag;
  logic power_down_flag;
  logic [3:0] pins_sync;
  logic ext_int_s;
  logic master_clear_input_s;
  logic bor_s;
  logic por_s;
  logic reset_event;
  logic int_pending;
  logic [NUM_INT-1:0] csw_mask;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic go_sleep;
  logic go_idle;
  logic sleep_wake;
  logic dly_load;
  logic dly_busy;
  logic [DLY_W-1:0] dly_val;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation; master clear inverted first so that the
  // synchroniser's zero reset value reads as released, not pressed
  siw_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({ext_int_pin, ~master_clear_input_b, brownout_reset,
               power_on_reset}),
    .sync_out(pins_sync)
  );
  assign ext_int_s = pins_sync[3];
  assign master_clear_input_s = pins_sync[2];
  assign bor_s = pins_sync[1];
  assign por_s = pins_sync[0];
  assign reset_event = master_clear_input_s || bor_s || por_s;

  // Clock-switch interrupt never counts as pending
  always_comb begin
    csw_mask = '1;
    csw_mask[CSW_INT_IDX] = 1'b0;
  end
  assign int_pending = |(int_flags & int_enables & csw_mask)
                       || (ext_int_s && ext_int_enable);

  // Sleep decisions; a pending interrupt with GLOBAL_INTERRUPT_ENABLE clear makes a no-op
  assign go_sleep = state == ST_RUN && sleep_exec && !doze_idle_control.idle_select
                    && !(int_pending && !global_interrupt_enable);
  assign go_idle = state == ST_RUN && sleep_exec && doze_idle_control.idle_select
                   && !(int_pending && !global_interrupt_enable);
  assign sleep_wake = state == ST_SLEEP && !reset_event
                      && (int_pending || wdt_timeout);

  ////////////////////////////////////////////////////////////////////////
  // Wake-up delay: oscillator start-up plus regulator settling
  always_comb begin
    dly_val = '0;
    if (osc_is_crystal) begin
      dly_val = dly_val + DLY_W'(OST_CYCLES);
    end
    if (regulator_low_power_sleep) begin
      dly_val = dly_val + DLY_W'(REG_CYCLES);
    end
  end
  assign dly_load = sleep_wake;

  siw_delay_cnt #(.W(DLY_W)) u_dly (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(dly_load),
    .load_val(dly_val),
    .busy(dly_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode state machine; reset pins override every state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= ST_RUN;
    end else if (reset_event) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (go_sleep) begin
            state <= ST_SLEEP;
          end else if (go_idle) begin
            state <= ST_IDLE;
          end
        end
        ST_SLEEP: begin
          if (sleep_wake) begin
            state <= (dly_val != '0) ? ST_WAKE_DLY : ST_RESUME;
          end
        end
        ST_IDLE: begin
          if (int_pending || wdt_timeout) begin
            state <= ST_RESUME;
          end
        end
        ST_WAKE_DLY: begin
          if (!dly_busy) begin
            state <= ST_RESUME;
          end
        end
        ST_RESUME: state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  // Remember what woke us, for the vector decision
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wake_cause <= '0;
    end else if (sleep_wake || (state == ST_IDLE
                 && (int_pending || wdt_timeout))) begin
      wake_cause.by_int <= int_pending;
      wake_cause.by_wdt <= wdt_timeout && !int_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: power-on/brown-out set both, sleep entry sets timeout
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      timeout_flag <= RST_TIMEOUT;
      power_down_flag <= RST_POWER_DOWN;
    end else if (por_s || bor_s) begin
      timeout_flag <= RST_TIMEOUT;
      power_down_flag <= RST_POWER_DOWN;
    end else if (go_sleep) begin
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b0;
    end else if (sleep_wake && wdt_timeout && !int_pending) begin
      timeout_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog clear on entry and on every wake from Sleep
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wdt_clear <= 1'b0;
      wdt_run_in_sleep <= 1'b0;
    end else begin
      wdt_clear <= go_sleep || sleep_wake;
      wdt_run_in_sleep <= go_sleep ? wdt_sleep_enable
                          : (state == ST_SLEEP && !sleep_wake
                             && wdt_run_in_sleep);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock gating per mode; only Sleep stops the system clock
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cpu_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      periph_fosc_clk_en <= 1'b1;
      clock_output_pin_en <= 1'b1;
      low_freq_internal_osc_run <= 1'b1;
      high_freq_internal_osc_run <= 1'b1;
      secondary_osc_run <= 1'b1;
    end else begin
      // Oscillators of their own never stop here
      low_freq_internal_osc_run <= 1'b1;
      high_freq_internal_osc_run <= 1'b1;
      secondary_osc_run <= 1'b1;
      if (reset_event || state == ST_RESUME) begin
        cpu_clk_en <= 1'b1;
        sys_clk_en <= 1'b1;
        periph_fosc_clk_en <= 1'b1;
        clock_output_pin_en <= 1'b1;
      end else if (go_sleep) begin
        cpu_clk_en <= 1'b0;
        sys_clk_en <= 1'b0;
        periph_fosc_clk_en <= 1'b0;
        clock_output_pin_en <= 1'b0;
      end else if (go_idle) begin
        cpu_clk_en <= 1'b0;
        periph_fosc_clk_en <= 1'b1;
        clock_output_pin_en <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Side effects: converter abort, I/O hold, regulator mode, mode flags
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      adc_abort <= 1'b0;
      io_hold <= 1'b0;
      regulator_low_power <= 1'b0;
      in_sleep <= 1'b0;
      in_idle <= 1'b0;
    end else begin
      adc_abort <= go_sleep && adc_on_system_clk;
      if (go_sleep) begin
        io_hold <= 1'b1;
        regulator_low_power <= regulator_low_power_sleep;
      end else if (sleep_wake || reset_event) begin
        io_hold <= 1'b0;
        regulator_low_power <= 1'b0;
      end
      in_sleep <= (go_sleep || (state == ST_SLEEP && !sleep_wake))
                  && !reset_event;
      in_idle <= (go_idle || (state == ST_IDLE && !int_pending
                  && !wdt_timeout)) && !reset_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program flow: prefetch, resume in line, vector, reset request
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prefetch_next <= 1'b0;
      resume_next <= 1'b0;
      vector_to_isr <= 1'b0;
      device_reset_req <= 1'b0;
    end else begin
      prefetch_next <= state == ST_RUN && sleep_exec;
      resume_next <= state == ST_RESUME;
      vector_to_isr <= state == ST_RESUME && wake_cause.by_int
                       && global_interrupt_enable;
      // Watchdog resets only while running
      device_reset_req <= reset_event
                          || (state == ST_RUN && wdt_timeout);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, unmapped addresses error
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && penable && !pready && !pwrite;
  assign addr_ok = paddr == ADDR_DOZE_IDLE || paddr == ADDR_VREG
                   || paddr == ADDR_STATUS;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata <= '0;
      if (apb_rd) begin
        case (paddr)
          ADDR_DOZE_IDLE: begin
            prdata[BIT_IDLE_SELECT] <= doze_idle_control.idle_select;
            prdata[BIT_DOZE_ENABLE] <= doze_idle_control.doze_enable_bit;
            prdata[BIT_ROI] <= doze_idle_control.recover_on_interrupt;
            prdata[BIT_DOE] <= doze_idle_control.doze_on_exit;
            prdata[BIT_RATIO_LO +: RATIO_W] <= doze_idle_control.ratio;
          end
          ADDR_VREG: begin
            prdata[BIT_REG_LP] <= regulator_low_power_sleep;
            prdata[BIT_VREG_FIXED_ONE] <= 1'b1;
          end
          ADDR_STATUS: begin
            prdata[BIT_TIMEOUT] <= timeout_flag;
            prdata[BIT_POWER_DOWN] <= power_down_flag;
            prdata[BIT_IN_IDLE] <= state == ST_IDLE;
            prdata[BIT_IN_SLEEP] <= state == ST_SLEEP;
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Doze/idle control; hardware doze clear beats a same-cycle write
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      doze_idle_control <= '0;
      regulator_low_power_sleep <= 1'b0;
      doze_enable <= 1'b0;
    end else begin
      if (apb_wr && paddr == ADDR_DOZE_IDLE) begin
        doze_idle_control.idle_select <= pwdata[BIT_IDLE_SELECT];
        doze_idle_control.doze_enable_bit <= pwdata[BIT_DOZE_ENABLE];
        doze_idle_control.recover_on_interrupt <= pwdata[BIT_ROI];
        doze_idle_control.doze_on_exit <= pwdata[BIT_DOE];
        doze_idle_control.ratio <= pwdata[BIT_RATIO_LO +: RATIO_W];
      end
      if ((state == ST_IDLE && int_pending && !reset_event
           && doze_idle_control.recover_on_interrupt)
          || (handler_entry && doze_idle_control.recover_on_interrupt)) begin
        doze_idle_control.doze_enable_bit <= 1'b0;
      end
      if (apb_wr && paddr == ADDR_VREG) begin
        regulator_low_power_sleep <= pwdata[BIT_REG_LP];
      end
      doze_enable <= doze_idle_control.doze_enable_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_sleep_cmd;
    state == ST_RUN && sleep_exec && !reset_event
      && !(int_pending && !global_interrupt_enable);
  endsequence

  property p_sleep_entry;
    s_sleep_cmd and (!doze_idle_control.idle_select) |=> state == ST_SLEEP
      && !power_down_flag && timeout_flag && wdt_clear;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry effects missing");

  property p_idle_entry;
    s_sleep_cmd and (doze_idle_control.idle_select) |=> state == ST_IDLE
      && !cpu_clk_en && periph_fosc_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle entry wrong");

  property p_nop_sleep;
    state == ST_RUN && sleep_exec && int_pending && !global_interrupt_enable
      && !reset_event && !por_s && !bor_s
      |=> state == ST_RUN && $stable(power_down_flag)
      && $stable(timeout_flag) && !wdt_clear;
  endproperty
  a_nop_sleep: assert property (p_nop_sleep)
    else $error("pending interrupt did not make sleep a no-op");

  property p_sleep_clocks_off;
    state == ST_SLEEP |-> !cpu_clk_en && !sys_clk_en && io_hold;
  endproperty
  a_sleep_clocks_off: assert property (p_sleep_clocks_off)
    else $error("clocks running in sleep");

  property p_wake_clears_wdt;
    sleep_wake |=> wdt_clear;
  endproperty
  a_wake_clears_wdt: assert property (p_wake_clears_wdt)
    else $error("wake did not clear watchdog");

  property p_fast_wake;
    sleep_wake && dly_val == '0 |=> state == ST_RESUME ##1 resume_next;
  endproperty
  a_fast_wake: assert property (p_fast_wake)
    else $error("wake without delay not immediate");

  // Cycles spent waiting; a long start-up needs no long repetition
  logic [DLY_W-1:0] wait_cnt;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wait_cnt <= '0;
    end else if (state == ST_WAKE_DLY) begin
      wait_cnt <= wait_cnt + DLY_W'(1);
    end else begin
      wait_cnt <= '0;
    end
  end

  property p_ost_wait;
    state == ST_WAKE_DLY && !dly_busy && osc_is_crystal
      |-> wait_cnt >= DLY_W'(OST_CYCLES);
  endproperty
  a_ost_wait: assert property (p_ost_wait)
    else $error("start-up delay skipped");

  property p_idle_exit;
    state == ST_IDLE && int_pending && !reset_event
      |=> state == ST_RESUME && $stable(doze_idle_control.idle_select);
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("interrupt did not end idle");

  property p_idle_wdt;
    state == ST_IDLE && wdt_timeout && !int_pending && !reset_event
      && !handler_entry && !apb_wr
      |=> !device_reset_req && $stable(doze_idle_control.doze_enable_bit);
  endproperty
  a_idle_wdt: assert property (p_idle_wdt)
    else $error("watchdog in idle reset or touched doze");

  property p_roi_handler;
    handler_entry && doze_idle_control.recover_on_interrupt |=>
      !doze_idle_control.doze_enable_bit;
  endproperty
  a_roi_handler: assert property (p_roi_handler)
    else $error("handler entry kept doze");

  property p_reset_pins;
    reset_event |=> device_reset_req && state == ST_RUN;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("reset pin did not reset");

endmodule

//--- bench/siw_core_model.sv
// Behavioural CPU core and interrupt source facing the sequencer
`timescale 1ns/1ps
module siw_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bench requests
  input wire logic go_sleep,
  input wire logic raise_int,
  // Sequencer side
  input wire logic vector_to_isr,
  output logic sleep_exec,
  output logic handler_entry,
  output logic [7:0] int_flags
);
  // Sleep is a one-cycle pulse; the flag stays up until the bench drops it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sleep_exec <= 1'h0;
      handler_entry <= 1'h0;
      int_flags <= 8'h00;
    end else begin
      sleep_exec <= go_sleep;
      handler_entry <= vector_to_isr;
      int_flags <= {7'h00, raise_int};
    end
  end
endmodule

//--- bench/tb_siw_top.sv
// Self-checking bench for the sleep, idle and wake sequencer
`timescale 1ns/1ps
module tb_siw_top import siw_pkg::*; ;
  // Short wake delays keep the run brief
  localparam int OST_C = 4;
  localparam int REG_C = 3;
  logic core_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, sleep_exec, handler_entry, vec;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic global_interrupt_enable = 1'h0, osc_is_crystal = 1'h0;
  logic adc_on_system_clk = 1'h0, wdt_timeout = 1'h0, ext_int_pin = 1'h0;
  logic wdt_sleep_enable = 1'h0, ext_int_enable = 1'h0;
  logic master_clear_input_b = 1'h1, brownout_reset = 1'h0;
  logic power_on_reset = 1'h0, go_sleep = 1'h0, raise_int = 1'h0;
  logic [7:0] int_flags, int_enables = 8'h01;
  logic cpu_clk_en, sys_clk_en, periph_fosc_clk_en, clock_output_pin_en;
  logic low_freq_internal_osc_run, high_freq_internal_osc_run;
  logic secondary_osc_run, regulator_low_power, wdt_clear, wdt_run_in_sleep;
  logic adc_abort, io_hold, prefetch_next, resume_next, vector_to_isr;
  logic device_reset_req, doze_enable, in_sleep, in_idle;
  int n_fail = 0, tests_run = 0, gap;

  always #2 core_clk = ~core_clk;
  siw_top #(.OST_CYCLES(OST_C), .REG_CYCLES(REG_C)) siw_top_i (.*);
  siw_core_model siw_core_model_i (.*);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // APB cycle; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic e);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'h1) break;
    end
    chk(pready, 32'h1);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    logic e;
    apb(1'h0, a, 32'h0, e);
    chk(rd, x);
    chk(e, xe);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'h1, a, d, e);
    chk(e, 32'h0);
  endtask

  // Outputs are looked at just after the edge that takes the instruction
  task automatic sleep_pulse();
    @(posedge core_clk);
    go_sleep <= 1'h1;
    @(posedge core_clk);
    go_sleep <= 1'h0;
    @(posedge core_clk);
    #1;
  endtask

  // Gap from watchdog clear to resume; huge if the clear never came
  task automatic wake(output int g, output logic v);
    int t0;
    t0 = -1000;
    g = -1;
    v = 1'hx;
    for (int i = 1; i < 60 && g < 0; i++) begin
      @(posedge core_clk);
      #1;
      if (wdt_clear === 1'h1) t0 = i;
      if (resume_next === 1'h1) begin
        g = i - t0;
        v = vector_to_isr;
      end
    end
    chk(g >= 0, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(ADDR_STATUS, 32'h18, 1'h0);
    rdchk(ADDR_VREG, 32'h1, 1'h0);
    rdchk(12'h00C, 32'h0, 1'h1);
    $display("t_regs done");
  endtask

  // Disabled flag must not wake; enabling it does, after both delays
  task automatic t_sleep();
    wr(ADDR_VREG, 32'h3);
    osc_is_crystal <= 1'h1;
    adc_on_system_clk <= 1'h1;
    wdt_sleep_enable <= 1'h1;
    int_enables <= 8'h00;
    raise_int <= 1'h1;
    sleep_pulse();
    chk({in_sleep, in_idle, cpu_clk_en, sys_clk_en, periph_fosc_clk_en,
      io_hold, prefetch_next, wdt_clear, adc_abort, wdt_run_in_sleep,
      regulator_low_power, low_freq_internal_osc_run,
      high_freq_internal_osc_run, secondary_osc_run}, 32'h21FF);
    repeat (5) @(posedge core_clk);
    chk(in_sleep, 32'h1);
    int_enables <= 8'h01;
    wake(gap, vec);
    chk(gap >= 1 + OST_C + REG_C && gap < 20, 32'h1);
    chk({vec, device_reset_req}, 32'h0);
    chk({cpu_clk_en, sys_clk_en, io_hold}, 32'h6);
    rdchk(ADDR_STATUS, 32'h10, 1'h0);
    raise_int <= 1'h0;
    osc_is_crystal <= 1'h0;
    adc_on_system_clk <= 1'h0;
    wr(ADDR_VREG, 32'h1);
    $display("t_sleep done");
  endtask

  task automatic t_idle();
    wr(ADDR_DOZE_IDLE, 32'hE0);
    global_interrupt_enable <= 1'h1;
    sleep_pulse();
    chk({in_idle, in_sleep, cpu_clk_en, sys_clk_en, periph_fosc_clk_en,
      clock_output_pin_en}, 32'h27);
    @(posedge core_clk);
    wdt_timeout <= 1'h1;
    @(posedge core_clk);
    wdt_timeout <= 1'h0;
    wake(gap, vec);
    chk({vec, device_reset_req}, 32'h0);
    rdchk(ADDR_DOZE_IDLE, 32'hE0, 1'h0);
    chk(doze_enable, 32'h1);
    sleep_pulse();
    chk(in_idle, 32'h1);
    @(posedge core_clk);
    raise_int <= 1'h1;
    wake(gap, vec);
    chk(vec, 32'h1);
    @(posedge core_clk);
    raise_int <= 1'h0;
    rdchk(ADDR_DOZE_IDLE, 32'hA0, 1'h0);
    chk(doze_enable, 32'h0);
    $display("t_idle done");
  endtask

  // Enabled flag already up with global enable clear: sleep does nothing
  task automatic t_pend();
    wr(ADDR_DOZE_IDLE, 32'h0);
    global_interrupt_enable <= 1'h0;
    raise_int <= 1'h1;
    repeat (3) @(posedge core_clk);
    sleep_pulse();
    chk({in_sleep, in_idle, wdt_clear, prefetch_next}, 32'h1);
    @(posedge core_clk);
    raise_int <= 1'h0;
    $display("t_pend done");
  endtask

  // No delay: wake follows the clear at once; then a pin reset in Sleep
  task automatic t_fast();
    sleep_pulse();
    chk(in_sleep, 32'h1);
    @(posedge core_clk);
    raise_int <= 1'h1;
    wake(gap, vec);
    chk(gap, 32'h1);
    chk(vec, 32'h0);
    @(posedge core_clk);
    raise_int <= 1'h0;
    rdchk(ADDR_STATUS, 32'h10, 1'h0);
    sleep_pulse();
    @(posedge core_clk);
    master_clear_input_b <= 1'h0;
    repeat (4) @(posedge core_clk);
    chk({device_reset_req, in_sleep, cpu_clk_en}, 32'h5);
    master_clear_input_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    chk(device_reset_req, 32'h0);
    $display("t_fast done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_sleep();
    t_idle();
    t_pend();
    t_fast();
    print_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end
endmodule
